// File: shared/cflow_defs.vh
// Purpose: constants for the continuous flow-rate frame transmitter
// Assumes: one 50 MHz clock, asynchronous active-low reset
// Notes: character codes and timing counts used by the framer
// Behaviour
// - In mode 0 send flow rate frames whose length follows printed digit count.
// - Every frame byte is ASCII; the two check bytes are ASCII hex digits too.
// - Printed value fills positions 1 to Len-5, led by minus when negative.
// - Carriage return at Len-1 and line feed at Len close each frame.
`ifndef CFLOW_DEFS_VH
`define CFLOW_DEFS_VH
`define CFT_CLK_HZ      50000000
`define CFT_PERIOD_MS   100
`define CFT_MODE_FLOW   2'h0
`define CFT_CH_MINUS    8'h2D
`define CFT_CH_POINT    8'h2E
`define CFT_CH_ZERO     8'h30
`define CFT_CH_ALPHA    8'h37
`define CFT_CH_UNIT0    8'h44
`define CFT_CH_BLANK    8'h20
`define CFT_CH_CR       8'h0D
`define CFT_CH_LF       8'h0A
`define CFT_UNIT_MAX    3'h5
`define CFT_FIFO_DEPTH  8
`endif

// File: hdl/continuous_flow_frame_tx.v
// Purpose: builds flow-rate text frames and queues them towards a serial sender
// Assumes: inputs synchronous to clock_i; the serial sender drains char_* by valid/ready
// Notes: check bytes are the 8-bit sum of bytes 1..Len-4 printed as two hex digits
`timescale 1ns/1ps
`default_nettype none
`include "cflow_defs.vh"

module frame_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `CFT_FIFO_DEPTH,
  parameter AW    = 3
) (
  input  wire             clock_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wr_ptr_r;
  reg [AW:0]      rd_ptr_r;
  wire            empty;
  wire            full;
  wire            push;
  wire            pop;

  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign full        = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;

  always @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module continuous_flow_frame_tx #(
  parameter VW              = 24,
  parameter DIG_MAX         = 8,
  parameter SEND_PERIOD_CYC = `CFT_PERIOD_MS * (`CFT_CLK_HZ / 1000)
) (
  input  wire          clock_i,
  input  wire          rst_b_i,
  input  wire [1:0]    comm_mode_i,
  input  wire          period_en_i,
  input  wire          send_i,
  input  wire [VW-1:0] flow_value_i,
  input  wire [2:0]    dec_places_i,
  input  wire [2:0]    unit_code_i,
  output wire [7:0]    char_data_o,
  output wire          char_valid_o,
  input  wire          char_ready_i,
  output wire          busy_o
);
  localparam S_IDLE  = 4'h0;
  localparam S_CONV  = 4'h1;
  localparam S_SIGN  = 4'h2;
  localparam S_DIGIT = 4'h3;
  localparam S_POINT = 4'h4;
  localparam S_UNIT  = 4'h5;
  localparam S_CKHI  = 4'h6;
  localparam S_CKLO  = 4'h7;
  localparam S_CR    = 4'h8;
  localparam S_LF    = 4'h9;
  // Divisor sized to the value so the quotient and remainder keep their own widths
  localparam [VW-1:0] TEN = {{(VW-4){1'b0}}, 4'hA};

  function [7:0] hex_char;
    input [3:0] nib;
    begin
      hex_char = (nib < 4'hA) ? (`CFT_CH_ZERO + {4'h0, nib}) : (`CFT_CH_ALPHA + {4'h0, nib});
    end
  endfunction

  reg  [3:0]    state_r;
  reg  [VW-1:0] mag_r;
  reg           neg_r;
  reg  [2:0]    dec_r;
  reg  [2:0]    unit_r;
  reg  [3:0]    digit_r [0:DIG_MAX-1];
  reg  [3:0]    ndig_r;
  reg  [3:0]    pos_r;
  reg  [7:0]    sum_r;
  reg  [31:0]   tick_cnt_r;
  reg           pending_r;
  reg  [7:0]    push_data;
  reg           push_valid;
  wire          fifo_ready;
  wire          start;
  wire          tick;
  wire          adv;
  wire [VW-1:0] mag_div;
  wire [3:0]    mag_rem;
  wire [VW-1:0] mag_low;
  wire [3:0]    ndig_nxt;

  assign tick     = period_en_i && (tick_cnt_r == SEND_PERIOD_CYC - 1);
  assign start    = (state_r == S_IDLE) && (comm_mode_i == `CFT_MODE_FLOW) && (send_i | pending_r);
  assign adv      = push_valid & fifo_ready;
  assign mag_div  = mag_r / TEN;
  assign mag_low  = mag_r - mag_div * TEN;
  assign mag_rem  = mag_low[3:0];
  assign ndig_nxt = ndig_r + 4'h1;
  assign busy_o   = (state_r != S_IDLE);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 32'h0;
      pending_r  <= 1'b0;
    end else begin
      tick_cnt_r <= (tick || !period_en_i) ? 32'h0 : tick_cnt_r + 32'h1;
      // A tick during a busy frame is held, and wins over the clear by start
      pending_r  <= tick | (pending_r & ~start);
    end
  end

  // Digit store needs no reset: every frame rewrites the digits it prints
  always @(posedge clock_i) begin
    if (state_r == S_CONV) begin
      digit_r[ndig_r[2:0]] <= mag_rem;
    end
  end

  always @* begin
    push_valid = 1'b1;
    push_data  = `CFT_CH_BLANK;
    case (state_r)
      S_SIGN:  push_data = `CFT_CH_MINUS;
      S_DIGIT: push_data = `CFT_CH_ZERO + {4'h0, digit_r[pos_r[2:0]]};
      S_POINT: push_data = `CFT_CH_POINT;
      S_UNIT:  push_data = (unit_r <= `CFT_UNIT_MAX) ? (`CFT_CH_UNIT0 + {5'h0, unit_r}) : `CFT_CH_BLANK;
      S_CKHI:  push_data = hex_char(sum_r[7:4]);
      S_CKLO:  push_data = hex_char(sum_r[3:0]);
      S_CR:    push_data = `CFT_CH_CR;
      S_LF:    push_data = `CFT_CH_LF;
      default: push_valid = 1'b0;
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= S_IDLE;
      mag_r   <= {VW{1'b0}};
      neg_r   <= 1'b0;
      dec_r   <= 3'h0;
      unit_r  <= 3'h0;
      ndig_r  <= 4'h0;
      pos_r   <= 4'h0;
      sum_r   <= 8'h0;
    end else begin
      if (adv && (state_r != S_CKHI) && (state_r != S_CKLO) && (state_r != S_CR) && (state_r != S_LF)) begin
        sum_r <= sum_r + push_data;
      end
      case (state_r)
        S_IDLE: begin
          if (start) begin
            neg_r   <= flow_value_i[VW-1];
            mag_r   <= flow_value_i[VW-1] ? (~flow_value_i + {{(VW-1){1'b0}}, 1'b1}) : flow_value_i;
            dec_r   <= dec_places_i;
            unit_r  <= unit_code_i;
            ndig_r  <= 4'h0;
            sum_r   <= 8'h0;
            state_r <= S_CONV;
          end
        end
        S_CONV: begin
          mag_r  <= mag_div;
          ndig_r <= ndig_nxt;
          if (((mag_div == {VW{1'b0}}) && (ndig_nxt > {1'b0, dec_r})) || (ndig_nxt == DIG_MAX)) begin
            pos_r   <= ndig_r;
            state_r <= neg_r ? S_SIGN : S_DIGIT;
          end
        end
        S_SIGN: begin
          if (adv) begin
            state_r <= S_DIGIT;
          end
        end
        S_DIGIT: begin
          if (adv) begin
            pos_r <= pos_r - 4'h1;
            if (pos_r == 4'h0) begin
              state_r <= S_UNIT;
            end else if ((pos_r == {1'b0, dec_r}) && (dec_r != 3'h0)) begin
              state_r <= S_POINT;
            end
          end
        end
        S_POINT: begin
          if (adv) begin
            state_r <= S_DIGIT;
          end
        end
        S_UNIT: begin
          if (adv) begin
            state_r <= S_CKHI;
          end
        end
        S_CKHI: begin
          if (adv) begin
            state_r <= S_CKLO;
          end
        end
        S_CKLO: begin
          if (adv) begin
            state_r <= S_CR;
          end
        end
        S_CR: begin
          if (adv) begin
            state_r <= S_LF;
          end
        end
        S_LF: begin
          if (adv) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Queue decouples frame building from a slow serial line
  frame_fifo #(
    .WIDTH (8),
    .DEPTH (`CFT_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (push_data),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_ready),
    .out_data_o  (char_data_o),
    .out_valid_o (char_valid_o),
    .out_ready_i (char_ready_i)
  );
endmodule
`default_nettype wire

// File: tb/cflow_tx_asserts.sv
// Purpose: port checks for the flow-rate frame transmitter
// Assumes: one clock domain, reset active low
// Notes: pop means the host took the head character
`timescale 1ns/1ps
`default_nettype none
module cflow_tx_asserts (
  input wire       clock_i,
  input wire       rst_b_i,
  input wire [1:0] comm_mode_i,
  input wire       period_en_i,
  input wire       send_i,
  input wire [7:0] char_data_o,
  input wire       char_valid_o,
  input wire       char_ready_i,
  input wire       busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire pop = char_valid_o && char_ready_i;
  mode_gate_a: assert property (!busy_o && comm_mode_i != 2'h0 |=> !busy_o)
    else $error("frame started outside mode 0");
  send_start_a: assert property (send_i && !busy_o && comm_mode_i == 2'h0 |=> busy_o)
    else $error("send request not taken");
  ascii_only_a: assert property (char_valid_o |-> !char_data_o[7])
    else $error("non ASCII character offered");
  minus_digit_a: assert property (pop && char_data_o == 8'h2D |=> char_valid_o && char_data_o inside {[8'h30:8'h39]})
    else $error("minus not followed by a digit");
  cr_then_lf_a: assert property (pop && char_data_o == 8'h0D |=> char_valid_o && char_data_o == 8'h0A)
    else $error("carriage return not followed by line feed");
endmodule
`default_nettype wire

// File: tb/cflow_host_model.sv
// Purpose: host taking characters from the frame stream
// Assumes: valid/ready, one character per accepted edge
// Notes: alternates slow phases, which fill the FIFO, with fast ones
`timescale 1ns/1ps
`default_nettype none
module cflow_host_model (
  input  wire        clock_i,
  input  wire        char_valid_i,
  input  wire  [7:0] char_data_i,
  output logic       char_ready_o = 1'b0,
  output logic       got_o = 1'b0,
  output logic [7:0] got_data_o = 8'h00
);
  logic [5:0] phase_r = 6'h00;
  always @(negedge clock_i) begin
    phase_r <= phase_r + 6'h01;
    char_ready_o <= phase_r[5] ? 1'b1 : ($urandom % 8 == 0);
  end
  always @(posedge clock_i) begin
    got_o <= char_valid_i && char_ready_o;
    got_data_o <= char_data_i;
  end
endmodule
`default_nettype wire

// File: tb/continuous_flow_frame_tx_bench.sv
// Purpose: random and corner frames checked byte by byte
// Assumes: header path on the include list
// Notes: periodic sending is on only in the timed section; all other frames come from send_i
`timescale 1ns/1ps
`default_nettype none
`include "cflow_defs.vh"
module continuous_flow_frame_tx_bench;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        send_i = 1'b0;
  logic        period_en_i = 1'b0;
  logic [1:0]  comm_mode_i = 2'h0;
  logic [23:0] flow_value_i = 24'h000000;
  logic [2:0]  dec_places_i = 3'h0;
  logic [2:0]  unit_code_i = 3'h0;
  wire  [7:0]  char_data_o;
  wire  [7:0]  got_data;
  wire         char_valid_o;
  wire         char_ready_i;
  wire         busy_o;
  wire         got;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n;
  int          v;
  int          w;
  logic        bz;
  logic [7:0]  exp[$];
  logic [7:0]  sm;
  continuous_flow_frame_tx #(.SEND_PERIOD_CYC(50)) u_continuous_flow_frame_tx (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .comm_mode_i(comm_mode_i), .period_en_i(period_en_i), .send_i(send_i),
    .flow_value_i(flow_value_i), .dec_places_i(dec_places_i), .unit_code_i(unit_code_i),
    .char_data_o(char_data_o), .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .busy_o(busy_o));
  cflow_host_model u_cflow_host_model (.clock_i(clock_i), .char_valid_i(char_valid_o),
    .char_data_i(char_data_o), .char_ready_o(char_ready_i), .got_o(got), .got_data_o(got_data));
  initial forever #10 clock_i = ~clock_i;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task end_of_test;
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task put(input logic [7:0] c);
    exp.push_back(c);
    sm = sm + c;
  endtask
  function logic [7:0] hx(input logic [3:0] x);
    return (x < 4'hA) ? `CFT_CH_ZERO + x : `CFT_CH_ALPHA + x;
  endfunction
  // Expected frame: sign, digits with point, unit, check, CR LF
  task mk(input int val, input int d, input int u);
    int a;
    int i;
    int nd;
    int dg[8];
    a = (val < 0) ? -val : val;
    sm = 8'h00;
    if (val < 0) put(`CFT_CH_MINUS);
    for (i = 0; i < 8; i++) begin
      dg[i] = a % 10;
      a = a / 10;
    end
    nd = 1;
    for (i = 1; i < 8; i++) if (dg[i] != 0 || i <= d) nd = i + 1;
    for (i = nd - 1; i >= 0; i--) begin
      if (d > 0 && i == d - 1) put(`CFT_CH_POINT);
      put(`CFT_CH_ZERO + dg[i][7:0]);
    end
    put(u < 6 ? `CFT_CH_UNIT0 + u[7:0] : `CFT_CH_BLANK);
    exp.push_back(hx(sm[7:4]));
    exp.push_back(hx(sm[3:0]));
    exp.push_back(`CFT_CH_CR);
    exp.push_back(`CFT_CH_LF);
  endtask
  task wt;
    int k;
    for (k = 0; k < 600 && (busy_o !== 1'b0 || exp.size() > 0); k++) @(negedge clock_i);
    if (k == 600) begin
      chk("frame done", 8'h00, 8'h01);
      end_of_test();
    end
  endtask
  always @(negedge clock_i) begin
    if (got === 1'b1) chk("char", got_data, exp.size() > 0 ? exp.pop_front() : 8'hXX);
  end
  initial begin
    n = $urandom(90421);
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    rst_b_i = 1'b1;
    for (n = 0; n < 16; n++) begin
      v = int'($urandom % 2000000) - 1000000;
      dec_places_i = $urandom % 4;
      if (n == 0) begin
        v = -5;
        dec_places_i = 3'h0;
      end
      if (n == 1) begin
        v = 3;
        dec_places_i = 3'h7;
      end
      if (n == 2) v = 0;
      flow_value_i = v[23:0];
      unit_code_i = n % 8;
      send_i = 1'b1;
      mk(v, dec_places_i, unit_code_i);
      @(negedge clock_i);
      send_i = 1'b0;
      wt();
    end
    // Timed sending: each frame the framer starts by itself carries the held value
    v = int'($urandom % 2000) - 1000;
    flow_value_i = v[23:0];
    dec_places_i = 3'h1;
    unit_code_i = 3'h3;
    period_en_i = 1'b1;
    w = 0;
    bz = 1'b0;
    for (n = 0; n < 400; n++) begin
      @(negedge clock_i);
      // Stop ticking early so a remembered tick still lands inside the loop
      if (n == 250) period_en_i = 1'b0;
      if (busy_o === 1'b1 && bz !== 1'b1) begin
        mk(v, 1, 3);
        w++;
      end
      bz = busy_o;
    end
    wt();
    chk("periodic frames", (w >= 2) ? 8'h01 : 8'h00, 8'h01);
    // A request outside mode 0 is dropped, not queued
    comm_mode_i = 2'h1 + ($urandom % 3);
    send_i = 1'b1;
    @(negedge clock_i);
    send_i = 1'b0;
    repeat (12) @(negedge clock_i);
    chk("busy", {7'h00, busy_o}, 8'h00);
    chk("valid", {7'h00, char_valid_o}, 8'h00);
    end_of_test();
  end
endmodule
bind continuous_flow_frame_tx cflow_tx_asserts u_cflow_tx_asserts (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .comm_mode_i(comm_mode_i), .period_en_i(period_en_i), .send_i(send_i), .char_data_o(char_data_o),
  .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .busy_o(busy_o));
`default_nettype wire
